/* File: logic/spt_pkg.sv */
// Constants, formats and register map of the SSI position transmitter.
// Assumes a 10 MHz core clock and an APB master with 32-bit data.
//
// Overview of operation
// - Rising link edges shift bits out, MSB first
// - Frame ends after 20 us without edges
// - 24-bit-with-error: 24 data bits plus error bit
// - Plain 24-bit formats send 24 data bits
// - 25-bit formats send 25 data bits only
// - Status formats: 24 data bits, 8 status bits
// - Status one to four: inputs, laser, heater
// - Status five to eight: warnings and errors
// - Whole-word gray encodes data plus error bit
// - Warning only: real value plus warning flag
// - Measurement fault: value zero plus error
// - Extrapolate with plausibility warning during suppression
// - Warnings and errors are never latched

package spt_pkg;

  // ----------------------------------------------------------------
  // Frame formats
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    GRAY24_WITH_ERROR_FORMAT = 4'h0,
    BINARY24_WITH_ERROR_FORMAT = 4'h1,
    GRAY24_FORMAT = 4'h2,
    BINARY24_FORMAT = 4'h3,
    GRAY25_FORMAT = 4'h4,
    BINARY25_FORMAT = 4'h5,
    GRAY24_PLUS_STATUS_FORMAT = 4'h6,
    BINARY24_PLUS_STATUS_FORMAT = 4'h7,
    WHOLE_WORD_GRAY_FORMAT = 4'h8
  } spt_format_t;

  typedef enum logic {
    SPT_IDLE = 1'b0,
    SPT_FRAME = 1'b1
  } spt_state_t;

  localparam int unsigned FRAME_LEN_24 = 24;
  localparam int unsigned FRAME_LEN_25 = 25;
  localparam int unsigned FRAME_LEN_32 = 32;
  localparam int unsigned DATA_W = 25;
  localparam int unsigned WORD_W = 32;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MONOFLOP_NS = 20000;
  localparam int unsigned MONOFLOP_CYCLES = MONOFLOP_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] SUPPRESS_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] CAPTURE_OFFSET = 8'h0C;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [31:0] SUPPRESS_RESET = 32'h000003E8;
  localparam int unsigned CTRL_FMT_LSB = 0;
  localparam int unsigned STAT_FRAME_BIT = 0;
  localparam int unsigned STAT_SUPP_BIT = 1;
  localparam int unsigned STAT_ERR_BIT = 2;
  localparam int unsigned STAT_FMT_LSB = 4;
  localparam int unsigned STAT_CNT_LSB = 8;

endpackage : spt_pkg

/* File: logic/spt_sync.sv */
// Two-flop synchroniser with edge detection for the SSI link clock.
// Assumes the input is asynchronous to clk; edges come from flop two.
`timescale 1ns/100ps
`default_nettype none

module spt_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic async_in,
  output logic rise,
  output logic fall
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // ----------------------------------------------------------------
  // Flop one is read only by flop two
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else if (ce) begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = ce & sync_q & ~last_q;
  assign fall = ce & ~sync_q & last_q;

endmodule : spt_sync

`default_nettype wire

/* File: logic/spt_transmitter.sv */
// SSI slave transmitter: frames the position word and shifts it out.
// Assumes position and condition inputs come from logic on CLK and
// that the SSI clock pin is asynchronous.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module spt_transmitter
  import spt_pkg::*;
#(
  parameter int unsigned MONO_CYCLES = MONOFLOP_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // SSI link
  input wire logic SSI_CLOCK,
  output logic SSI_DATA,
  // Measurement and conditions
  input wire logic [DATA_W-1:0] POSITION,
  input wire logic [DATA_W-1:0] EXTRAPOLATED_POSITION,
  input wire logic MULTIFUNCTION_INPUT_ONE,
  input wire logic MULTIFUNCTION_INPUT_TWO,
  input wire logic LASER_ACTIVE,
  input wire logic HEATER_ACTIVE,
  input wire logic TEMPERATURE_WARNING,
  input wire logic LEVEL_WARNING,
  input wire logic PLAUSIBILITY_WARNING,
  input wire logic LASER_WARNING,
  input wire logic TEMPERATURE_ERROR,
  input wire logic LEVEL_ERROR,
  input wire logic PLAUSIBILITY_ERROR,
  input wire logic LASER_ERROR
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] to_gray(
    input logic [DATA_W-1:0] bin
  );
    to_gray = bin ^ (bin >> 1);
  endfunction : to_gray

  function automatic logic [5:0] frame_len(input spt_format_t fmt);
    unique case (fmt)
      GRAY24_FORMAT, BINARY24_FORMAT: frame_len = 6'(FRAME_LEN_24);
      GRAY24_PLUS_STATUS_FORMAT, BINARY24_PLUS_STATUS_FORMAT:
        frame_len = 6'(FRAME_LEN_32);
      default: frame_len = 6'(FRAME_LEN_25);
    endcase
  endfunction : frame_len

  // ----------------------------------------------------------------
  // Link clock edges
  // ----------------------------------------------------------------
  logic link_rise;
  logic link_fall;

  spt_sync u_sync (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .async_in(SSI_CLOCK),
    .rise(link_rise),
    .fall(link_fall)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  spt_format_t format_q;
  logic [31:0] suppress_time_q;
  logic [31:0] suppress_cnt_q;
  spt_state_t state_q;
  spt_state_t state_d;
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] capture_q;
  spt_format_t frame_fmt_q;
  logic [5:0] bits_left_q;
  logic [$clog2(MONO_CYCLES+1)-1:0] mono_q;
  logic data_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // ----------------------------------------------------------------
  // Fault handling
  // ----------------------------------------------------------------
  // Conditions are taken live from the inputs so nothing is held
  // after it clears; only the suppression timer keeps history.
  logic fault;
  logic suppress_expired;
  logic suppressing;
  logic error_reported;
  logic [DATA_W-1:0] reported_pos;
  logic [7:0] status_byte;

  assign fault = TEMPERATURE_ERROR | LEVEL_ERROR | PLAUSIBILITY_ERROR |
                 LASER_ERROR;
  assign suppress_expired = (suppress_cnt_q >= suppress_time_q);
  assign suppressing = fault & ~suppress_expired;
  assign error_reported = fault & suppress_expired;

  always_ff @(posedge CLK) begin
    if (RST) begin
      suppress_cnt_q <= 32'h00000000;
    end else if (CE) begin
      if (!fault) begin
        suppress_cnt_q <= 32'h00000000;
      end else if (!suppress_expired) begin
        suppress_cnt_q <= suppress_cnt_q + 32'h00000001;
      end
    end
  end

  always_comb begin
    if (error_reported) begin
      reported_pos = '0;
    end else if (suppressing) begin
      reported_pos = EXTRAPOLATED_POSITION;
    end else begin
      reported_pos = POSITION;
    end
  end

  always_comb begin
    status_byte[0] = MULTIFUNCTION_INPUT_ONE;
    status_byte[1] = MULTIFUNCTION_INPUT_TWO;
    status_byte[2] = LASER_ACTIVE;
    status_byte[3] = HEATER_ACTIVE;
    status_byte[4] = TEMPERATURE_WARNING | LEVEL_WARNING |
                     PLAUSIBILITY_WARNING | suppressing;
    status_byte[5] = LASER_WARNING;
    status_byte[6] = error_reported & (TEMPERATURE_ERROR | LEVEL_ERROR |
                     PLAUSIBILITY_ERROR);
    status_byte[7] = error_reported & LASER_ERROR;
  end

  // ----------------------------------------------------------------
  // Frame word, left aligned so the MSB is bit 31
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] frame_word;
  logic [DATA_W-1:0] data24;
  logic [DATA_W-1:0] with_err;

  assign data24 = {1'b0, reported_pos[23:0]};
  assign with_err = {reported_pos[23:0], error_reported};

  always_comb begin
    frame_word = '0;
    unique case (format_q)
      GRAY24_WITH_ERROR_FORMAT:
        frame_word = ({to_gray(data24), 7'h00} << 1) |
                     {24'h000000, error_reported, 7'h00};
      BINARY24_WITH_ERROR_FORMAT:
        frame_word = {with_err, 7'h00};
      GRAY24_FORMAT:
        frame_word = {to_gray(data24), 7'h00} << 1;
      BINARY24_FORMAT:
        frame_word = {reported_pos[23:0], 8'h00};
      GRAY25_FORMAT:
        frame_word = {to_gray(reported_pos), 7'h00};
      BINARY25_FORMAT:
        frame_word = {reported_pos, 7'h00};
      GRAY24_PLUS_STATUS_FORMAT:
        frame_word = {to_gray(data24), 7'h00} << 1 |
                     {24'h000000, status_byte};
      BINARY24_PLUS_STATUS_FORMAT:
        frame_word = {reported_pos[23:0], status_byte};
      WHOLE_WORD_GRAY_FORMAT:
        frame_word = {to_gray(with_err), 7'h00};
      default:
        frame_word = {with_err, 7'h00};
    endcase
  end

  // ----------------------------------------------------------------
  // Frame state and monoflop
  // ----------------------------------------------------------------
  logic link_edge;
  logic mono_expired;

  assign link_edge = link_rise | link_fall;
  assign mono_expired = (mono_q == ($bits(mono_q))'(MONO_CYCLES - 1));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SPT_IDLE: begin
        if (link_edge) begin
          state_d = SPT_FRAME;
        end
      end
      SPT_FRAME: begin
        if (!link_edge && mono_expired) begin
          state_d = SPT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= SPT_IDLE;
    end else if (CE) begin
      state_q <= state_d;
    end
  end

  // Any edge retriggers; a slow master below the rate limits ends
  // the frame early, so the rate floor is a hard limit.
  always_ff @(posedge CLK) begin
    if (RST) begin
      mono_q <= '0;
    end else if (CE) begin
      if (state_q == SPT_IDLE || link_edge) begin
        mono_q <= '0;
      end else if (!mono_expired) begin
        mono_q <= mono_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture and shift
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      shift_q <= '0;
      capture_q <= '0;
      frame_fmt_q <= GRAY24_WITH_ERROR_FORMAT;
      bits_left_q <= 6'h00;
    end else if (CE) begin
      if (state_q == SPT_IDLE && link_edge) begin
        capture_q <= frame_word;
        frame_fmt_q <= format_q;
        if (link_rise) begin
          shift_q <= frame_word << 1;
          bits_left_q <= frame_len(format_q) - 6'h01;
        end else begin
          shift_q <= frame_word;
          bits_left_q <= frame_len(format_q);
        end
      end else if (state_q == SPT_FRAME && link_rise) begin
        shift_q <= shift_q << 1;
        if (bits_left_q != 6'h00) begin
          bits_left_q <= bits_left_q - 6'h01;
        end
      end
    end
  end

  // Past the last bit the line reads low until the monoflop ends.
  always_ff @(posedge CLK) begin
    if (RST) begin
      data_q <= 1'b1;
    end else if (CE) begin
      if (link_rise && (state_q == SPT_IDLE)) begin
        data_q <= frame_word[WORD_W-1];
      end else if (link_rise) begin
        data_q <= shift_q[WORD_W-1];
      end else if (state_d == SPT_IDLE) begin
        data_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------
  logic apb_access;
  logic apb_done;
  logic addr_ok;
  logic [31:0] read_word;

  assign apb_access = PSEL & PENABLE;
  assign apb_done = apb_access & pready_q;
  assign addr_ok = (PADDR == CTRL_OFFSET) || (PADDR == SUPPRESS_OFFSET) ||
                   (PADDR == STATUS_OFFSET) || (PADDR == CAPTURE_OFFSET);

  always_comb begin
    read_word = 32'h00000000;
    unique case (PADDR)
      CTRL_OFFSET: read_word[CTRL_FMT_LSB +: 4] = format_q;
      SUPPRESS_OFFSET: read_word = suppress_time_q;
      STATUS_OFFSET: begin
        read_word[STAT_FRAME_BIT] = (state_q == SPT_FRAME);
        read_word[STAT_SUPP_BIT] = suppressing;
        read_word[STAT_ERR_BIT] = error_reported;
        read_word[STAT_FMT_LSB +: 4] = frame_fmt_q;
        read_word[STAT_CNT_LSB +: 6] = bits_left_q;
      end
      CAPTURE_OFFSET: read_word = capture_q;
      default: read_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (CE) begin
      pready_q <= apb_access & ~pready_q;
      pslverr_q <= apb_access & ~pready_q & ~addr_ok;
      if (apb_access && !pready_q && !PWRITE) begin
        prdata_q <= read_word;
      end
    end
  end

  // Format changes apply at the next capture, never mid-frame.
  always_ff @(posedge CLK) begin
    if (RST) begin
      format_q <= spt_format_t'(CTRL_RESET);
      suppress_time_q <= SUPPRESS_RESET;
    end else if (CE && apb_done && PWRITE) begin
      if (PADDR == CTRL_OFFSET) begin
        format_q <= spt_format_t'(PWDATA[CTRL_FMT_LSB +: 4]);
      end
      if (PADDR == SUPPRESS_OFFSET) begin
        suppress_time_q <= PWDATA;
      end
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign SSI_DATA = data_q;

endmodule : spt_transmitter

`default_nettype wire

/* File: test/spt_transmitter_assertions.sv */
// Port checker for the SSI position transmitter.
// Assumes it is bound to spt_transmitter; the link clock is asynchronous.
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module spt_transmitter_assertions
  import spt_pkg::*;
#(
  parameter int unsigned MONO_CYCLES = MONOFLOP_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SSI_CLOCK,
  input wire logic SSI_DATA
);
  // Window allows for both synchronisers and the 15 to 25 spread
  localparam int MONO_MIN = MONO_CYCLES * 3 / 4;
  localparam int MONO_MAX = MONO_CYCLES * 5 / 4 + 6;
  logic pin_meta_q;
  logic pin_sync_q;
  logic [15:0] quiet_q;
  logic acc;
  logic unmapped;
  assign acc = PSEL && PENABLE && PREADY;
  assign unmapped = !(PADDR inside {CTRL_OFFSET, SUPPRESS_OFFSET,
                                    STATUS_OFFSET, CAPTURE_OFFSET});
  // Cycles since the link clock last moved, saturating
  always_ff @(posedge CLK) begin
    pin_meta_q <= SSI_CLOCK;
    pin_sync_q <= pin_meta_q;
    if (RST || pin_meta_q != pin_sync_q) begin
      quiet_q <= 16'h0000;
    end else if (quiet_q != 16'hFFFF) begin
      quiet_q <= quiet_q + 16'h0001;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  AST_IDLE_HIGH: assert property (quiet_q > MONO_MAX |-> SSI_DATA)
    else $error("data line not idle high");
  AST_FRAME_END: assert property ($rose(SSI_DATA) && quiet_q > 8 |->
    quiet_q >= MONO_MIN && quiet_q <= MONO_MAX)
    else $error("frame ended outside monoflop window");
  AST_DATA_STEADY: assert property ($changed(SSI_DATA) |->
    quiet_q <= 6 || quiet_q >= MONO_MIN)
    else $error("data changed without a link edge");
  AST_APB_WAIT: assert property (PSEL && !PENABLE |-> ##2 PREADY)
    else $error("ready not after one wait state");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_ERR_READY: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  AST_UNMAPPED: assert property (acc |-> PSLVERR == unmapped)
    else $error("error response wrong for address");
  AST_READ_HOLD: assert property ($changed(PRDATA) |-> PREADY)
    else $error("read data moved outside a transfer");
  cover property ($rose(SSI_DATA) && quiet_q > 8);
  cover property (acc && unmapped);
  cover property (acc && !unmapped);
endmodule : spt_transmitter_assertions
bind spt_transmitter spt_transmitter_assertions #(
  .MONO_CYCLES(MONO_CYCLES)
) u_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SSI_CLOCK(SSI_CLOCK), .SSI_DATA(SSI_DATA));
`default_nettype wire

/* File: test/spt_ssi_master.sv */
// SSI master model: clock bursts, MSB-first sampling of the data line.
// Assumes the device shifts a bit within 600 ns of each rising edge.
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Master
// ----------------------------------------------------------------
module spt_ssi_master #(
  parameter int PAUSE_NS = 3000
) (
  output logic ssi_clock,
  input wire logic ssi_data
);
  // Clock idles high; nothing is sent without a burst
  initial ssi_clock = 1'b1;
  // 1.25 MHz, fixed; not scaled with the shortened monoflop
  task automatic burst(input int n, output logic [31:0] word);
    word = 32'h00000000;
    // Pause scaled like the monoflop; odd offset breaks phase lock
    #(PAUSE_NS + 37);
    for (int i = 0; i < n; i++) begin
      ssi_clock = 1'b0;
      if (i > 0) begin
        #200;
        word = {word[30:0], ssi_data};
        #200;
      end else begin
        #400;
      end
      ssi_clock = 1'b1;
      #400;
    end
    #200;
    word = {word[30:0], ssi_data};
  endtask : burst
endmodule : spt_ssi_master
`default_nettype wire

/* File: test/spt_transmitter_tb.sv */
// Self-checking bench for the SSI position transmitter.
// Assumes the SSI master model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module spt_transmitter_tb
  import spt_pkg::*;
;
  localparam int MONO = 20;
  logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic SSI_CLOCK, SSI_DATA, rerr;
  logic [ADDR_W-1:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdat;
  logic [DATA_W-1:0] POSITION, EXTRAPOLATED_POSITION;
  // Errors 11:8, warnings 7:4, heater, laser, inputs two and one
  logic [11:0] cond;
  int bad_count = 0;
  int check_count = 0;
  spt_transmitter #(.MONO_CYCLES(MONO)) u_dut (.CLK(CLK), .RST(RST),
    .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SSI_CLOCK(SSI_CLOCK), .SSI_DATA(SSI_DATA),
    .POSITION(POSITION), .EXTRAPOLATED_POSITION(EXTRAPOLATED_POSITION),
    .MULTIFUNCTION_INPUT_ONE(cond[0]), .MULTIFUNCTION_INPUT_TWO(cond[1]),
    .LASER_ACTIVE(cond[2]), .HEATER_ACTIVE(cond[3]),
    .TEMPERATURE_WARNING(cond[4]), .LEVEL_WARNING(cond[5]),
    .PLAUSIBILITY_WARNING(cond[6]), .LASER_WARNING(cond[7]),
    .TEMPERATURE_ERROR(cond[8]), .LEVEL_ERROR(cond[9]),
    .PLAUSIBILITY_ERROR(cond[10]), .LASER_ERROR(cond[11]));
  spt_ssi_master #(.PAUSE_NS(3000)) u_master (.ssi_clock(SSI_CLOCK),
    .ssi_data(SSI_DATA));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  function automatic logic [31:0] exp_frame(input logic [3:0] f,
      input logic [24:0] p, input logic e, input logic [7:0] st);
    logic [23:0] b;
    logic [24:0] w;
    b = p[23:0];
    w = {b, e};
    case (f)
      4'h0: exp_frame = {7'h00, b ^ (b >> 1), e};
      4'h1: exp_frame = {7'h00, w};
      4'h2: exp_frame = {8'h00, b ^ (b >> 1)};
      4'h3: exp_frame = {8'h00, b};
      4'h4: exp_frame = {7'h00, p ^ (p >> 1)};
      4'h5: exp_frame = {7'h00, p};
      4'h6: exp_frame = {b ^ (b >> 1), st};
      4'h7: exp_frame = {b, st};
      default: exp_frame = {7'h00, w ^ (w >> 1)};
    endcase
  endfunction : exp_frame
  task automatic frame(input logic [3:0] f, input logic [24:0] pos,
                       input logic sup, input logic rep, input string name);
    logic [31:0] got;
    logic [31:0] exp;
    logic [31:0] stat;
    int n;
    n = (f == 4'h2 || f == 4'h3) ? 24 : (f == 4'h6 || f == 4'h7) ? 32 : 25;
    stat = (32'(f) << STAT_FMT_LSB) | (32'(sup) << STAT_SUPP_BIT) |
           (32'(rep) << STAT_ERR_BIT);
    exp = exp_frame(f, pos, rep, {cond[11] & rep, |cond[10:8] & rep,
      cond[7], |cond[6:4] | sup, cond[3:0]});
    fork
      u_master.burst(n, got);
      begin
        repeat (60) @(posedge CLK);
        POSITION <= ~POSITION;
        EXTRAPOLATED_POSITION <= ~EXTRAPOLATED_POSITION;
      end
    join
    check(name, got, exp);
    repeat (MONO + 10) @(posedge CLK);
    check("idle", SSI_DATA, 32'h1);
    apb(1'b0, CAPTURE_OFFSET, 32'h0, rdat, rerr);
    check("capture", rdat, exp << (32 - n));
    apb(1'b0, STATUS_OFFSET, 32'h0, rdat, rerr);
    check("status", rdat, stat);
  endtask : frame
  initial begin
    repeat (20000) @(posedge CLK);
    bad_count++;
    results();
  end
  initial begin
    RST = 1'b1;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    cond = 12'h000;
    POSITION = 25'h1A5C3E7;
    EXTRAPOLATED_POSITION = 25'h0BEEF12;
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    apb(1'b1, 8'h10, 32'h0000000F, rdat, rerr);
    check("unmapped write err", rerr, 32'h1);
    apb(1'b0, 8'h10, 32'h0, rdat, rerr);
    check("unmapped read", {rdat[30:0], rerr}, 32'h1);
    apb(1'b0, CTRL_OFFSET, 32'h0, rdat, rerr);
    check("ctrl reset", rdat, 32'h0);
    apb(1'b0, SUPPRESS_OFFSET, 32'h0, rdat, rerr);
    check("suppress reset", rdat, SUPPRESS_RESET);
    check("data reset", SSI_DATA, 32'h1);
    $display("test registers done");
    // Warnings only, so the live value must come out
    for (int f = 0; f < 9; f++) begin
      apb(1'b1, CTRL_OFFSET, {28'h0, f[3:0]}, rdat, rerr);
      cond <= 12'h095 ^ {8'h00, f[3:0]};
      @(posedge CLK);
      frame(f[3:0], POSITION, 1'b0, 1'b0, "frame");
    end
    $display("test formats done");
    apb(1'b1, SUPPRESS_OFFSET, 32'h00000190, rdat, rerr);
    for (int k = 0; k < 2; k++) begin
      logic [3:0] fm;
      fm = k ? 4'h8 : 4'h7;
      apb(1'b1, CTRL_OFFSET, {28'h0, fm}, rdat, rerr);
      cond <= 12'hA01;
      @(posedge CLK);
      frame(fm, EXTRAPOLATED_POSITION, 1'b1, 1'b0, "held");
      repeat (200) @(posedge CLK);
      frame(fm, 25'h0000000, 1'b0, 1'b1, "fault");
      cond <= 12'h001;
      @(posedge CLK);
      frame(fm, POSITION, 1'b0, 1'b0, "cleared");
    end
    $display("test faults done");
    results();
  end
endmodule : spt_transmitter_tb
`default_nettype wire
